//--- logic/watchdog_consts.svh
// Notes on behaviour
// - Reset MCU when armed counter expires
// - One option picks hardware or software arming
// - Software option: idle until arm bit set
// - Once armed, only MCU reset disarms
// - Inactive watchdog allows stop with oscillator off
// - Hardware option: stop acts as wait
// - After stop exit counting resumes in place
// - Reset value FE: arm clear, rest set
// - Writing soft-reset bit zero resets at once
// - Counter bit 6 falling triggers the reset
// - Register count bits map reversed to counter
// - 64 periods, 3072 to 196608 cycles
// - Hardware option: arm bit reads one always
// - Disarmed: free 7-bit timer, no reset
// - Counter clocked from internal clock over 3072
// - Watchdog reset held 2048 internal clocks
// - At least 28 instructions before reset
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH
// Register map
`define WDG_ADDR_COUNT_CONTROL 8'hD8
`define WDG_RESET_VALUE        8'hFE
// Field positions in the register
`define WDG_ARM_BIT            0
`define WDG_SOFT_RESET_BIT     1
// Timing: divide by 12, then 256 slow ticks per count step
`define WDG_CLK_DIV            12
`define WDG_STEP_TICKS         256
`define WDG_RESET_HOLD         2048
// Least guard after arming, in 13-clock machine cycles * 4 * 28
`define WDG_GUARD_CYCLES       1456
`endif

//--- logic/watchdog_pkg.sv
package watchdog_pkg;
  // Register bus request carrier
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  // Reset hold machine states
  typedef enum logic [1:0]
  {
    HOLD_IDLE = 2'b00,
    HOLD_BUSY = 2'b01
  } hold_state_t;
endpackage

//--- logic/wdg_tick_divider.sv
`timescale 1ns/1ps
`include "watchdog_consts.svh"
// Divides core clock by 12, then by 256: one pulse per 3072 clocks
module wdg_tick_divider
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Counting allowed
  input  wire logic run,
  // One-cycle step pulse
  output logic      step
);
  // All state in one struct
  typedef struct packed
  {
    logic [3:0] pre;
    logic [7:0] post;
    logic       step;
  } div_state_t;
  div_state_t st;
  div_state_t next_st;
  // Next-state logic; halting holds the phase so counting resumes
  always_comb
  begin
    next_st      = st;
    next_st.step = 1'b0;
    if (run)
    begin
      if (st.pre == 4'(`WDG_CLK_DIV - 1)) // Divide by twelve
      begin
        next_st.pre  = 4'h0;
        next_st.post = st.post + 8'h01;
        if (st.post == 8'(`WDG_STEP_TICKS - 1))
          next_st.step = 1'b1; // 12*256 = 3072 cycles per step
      end
      else
        next_st.pre = st.pre + 4'h1;
    end
  end
  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
  assign step = st.step;
endmodule

//--- logic/digital_watchdog_timer.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "watchdog_consts.svh"
module digital_watchdog_timer
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Non-volatile activation option: 1 = hardware, 0 = software
  input  wire logic       hw_option,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Core requests a stop; wake by interrupt
  input  wire logic       stop_req,
  input  wire logic       wake_irq,
  // Core-facing results
  output logic            mcu_reset,
  output logic            osc_halt,
  output logic            active
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed
  {
    logic [6:0]                ctr;     // Physical counter, bit 6 = soft reset
    logic                      arm;     // Arm bit
    logic                      stopped; // Oscillator halted
    watchdog_pkg::hold_state_t hold;
    logic [11:0]               hold_cnt;
    logic [10:0]               guard;   // Guard after arm or reset
    logic [7:0]                rdata;
    logic                      rst_out;
    logic                      act_out;
  } wdg_state_t;
  wdg_state_t st;
  wdg_state_t next_st;
  watchdog_pkg::reg_req_t req;  // Bundled bus request
  logic       step;             // Count step from divider
  logic       armed;            // Effective arm, option applied
  logic       hit;              // Register selected
  logic [6:0] load;             // Counter value from a write
  logic [6:0] dec;              // Counter minus one
  logic       fire;             // Reset cause this cycle
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign hit = (req.addr == `WDG_ADDR_COUNT_CONTROL);
  // Hardware option overrides the arm bit entirely
  assign armed = hw_option | st.arm;
  assign dec   = st.ctr - 7'h01;
  // ****************************************
  // Bit reversal between register and counter
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1)
    begin : g_rev
      // Register bit 7 is counter LSB, bit 2 is counter bit 5
      assign load[i] = req.wdata[7 - i];
    end
  endgenerate
  assign load[6] = req.wdata[`WDG_SOFT_RESET_BIT];
  // Divider keeps running unless oscillator is halted or reset is being held
  wdg_tick_divider u_div
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (!st.stopped && st.hold == watchdog_pkg::HOLD_IDLE),
    .step     (step)
  );
  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    next_st = st;
    fire    = 1'b0;
    // Guard counts down; cause is ignored until it expires
    if (st.guard != 11'h000)
      next_st.guard = st.guard - 11'h001;
    // Wake first, so a stop in the same cycle still wins (set wins)
    if (wake_irq)
      next_st.stopped = 1'b0; // Resume where halted
    // Stop entry: only when inactive is the oscillator halted
    // Hardware option: stop behaves as wait, counting goes on
    if (stop_req && !armed)
      next_st.stopped = 1'b1;
    if (step)
      next_st.ctr = dec;
    if (req.wr && hit)
    begin
      // Reload by software
      next_st.ctr = load;
      // Arm can only be set, never cleared by a write
      if (req.wdata[`WDG_ARM_BIT] && !st.arm)
      begin
        next_st.arm   = 1'b1;
        next_st.guard = 11'(`WDG_GUARD_CYCLES);
      end
    end
    // Falling edge of counter bit 6 causes reset when armed
    // Write with soft-reset bit zero gives the same edge
    // When disarmed the counter just wraps as a 7-bit timer
    // With step every 3072, 64 loads give 3072..196608
    if (armed && st.ctr[6] && !next_st.ctr[6] && st.guard == 11'h000)
      fire = 1'b1;
    // Reset hold machine
    case (st.hold)
      watchdog_pkg::HOLD_IDLE:
      begin
        if (fire)
        begin
          next_st.hold     = watchdog_pkg::HOLD_BUSY;
          next_st.hold_cnt = 12'(`WDG_RESET_HOLD - 1);
          next_st.rst_out  = 1'b1;
        end
      end
      watchdog_pkg::HOLD_BUSY:
      begin
        // Hold reset 2048 clocks, then reload as after reset
        if (st.hold_cnt == 12'h000)
        begin
          next_st          = '0;
          next_st.ctr      = 7'(`WDG_RESET_VALUE >> 1);
          next_st.guard    = 11'(`WDG_GUARD_CYCLES);
          next_st.hold     = watchdog_pkg::HOLD_IDLE;
        end
        else
          next_st.hold_cnt = st.hold_cnt - 12'h001;
      end
      default:
        next_st.hold = watchdog_pkg::HOLD_IDLE;
    endcase
    // Read data: counter reversed back, arm forced in hardware mode
    next_st.rdata = 8'h00;
    if (req.rd && hit)
    begin
      for (int k = 0; k < 6; k++)
        next_st.rdata[7 - k] = st.ctr[k];
      next_st.rdata[`WDG_SOFT_RESET_BIT] = st.ctr[6];
      next_st.rdata[`WDG_ARM_BIT]        = armed;
    end
    next_st.act_out = (next_st.hold == watchdog_pkg::HOLD_IDLE) &&
                      (hw_option | next_st.arm);
  end
  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      // Reset value FE: counter all ones, arm clear
      st       <= '0;
      st.ctr   <= 7'(`WDG_RESET_VALUE >> 1);
      st.guard <= 11'(`WDG_GUARD_CYCLES);
    end
    else
      st <= next_st;
  end
  assign reg_rdata = st.rdata;
  assign mcu_reset = st.rst_out;
  assign osc_halt  = st.stopped;
  assign active    = st.act_out;
endmodule

//--- bench/wdg_props.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module wdg_props
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Option, register port, core side
  input wire logic       hw_option,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       stop_req,
  input wire logic       wake_irq,
  input wire logic       mcu_reset,
  input wire logic       osc_halt,
  input wire logic       active
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Cycles the current reset pulse has stood
  logic [11:0] hold_cnt;
  always_ff @(posedge core_clk)
  begin
    hold_cnt <= (mcu_reset && rst_n) ? hold_cnt + 12'h001 : 12'h000;
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  hw_arm_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hD8
    && hw_option |-> reg_rdata[0])
    else $error("arm bit low in hardware mode");
  fire_armed_a: assert property ($rose(mcu_reset) |-> $past(active))
    else $error("reset while disarmed");
  hold_len_a: assert property ($fell(mcu_reset) |-> hold_cnt == 12'h800)
    else $error("reset pulse length wrong");
  arm_sticky_a: assert property (active |=> active || mcu_reset)
    else $error("armed watchdog dropped");
  hw_nostop_a: assert property (hw_option |-> !osc_halt)
    else $error("oscillator halted in hardware mode");
  stop_enter_a: assert property (stop_req && !active && !hw_option
    && !wake_irq && !mcu_reset |=> osc_halt) else $error("stop not taken");
  wake_exit_a: assert property (osc_halt && wake_irq |=> !osc_halt)
    else $error("wake not taken");
  cover property ($rose(mcu_reset));
  cover property ($rose(osc_halt));
  cover property ($rose(active));
endmodule

bind digital_watchdog_timer wdg_props u_props
(
  .core_clk(core_clk), .rst_n(rst_n), .hw_option(hw_option),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_req(stop_req),
  .wake_irq(wake_irq), .mcu_reset(mcu_reset), .osc_halt(osc_halt),
  .active(active)
);

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fails++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic core_clk, rst_n, hw_option, reg_wr, reg_rd, stop_req, wake_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       mcu_reset, osc_halt, active;
  logic       rd_d;    // Read strobe one cycle late
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  int         fails, total_checks, k;
  digital_watchdog_timer DUT (.core_clk(core_clk), .rst_n(rst_n),
    .hw_option(hw_option), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_req(stop_req), .wake_irq(wake_irq), .mcu_reset(mcu_reset),
    .osc_halt(osc_halt), .active(active));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1)
      `CHK("reg_rdata", exp_q.pop_front(), reg_rdata)
  end
  task automatic close_out();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(input logic opt);
    rst_n <= 1'b0;
    hw_option <= opt;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask
  // One strobe cycle, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic wake);
    if (wake) wake_irq <= 1'b1;
    else stop_req <= 1'b1;
    @(posedge core_clk);
    wake_irq <= 1'b0;
    stop_req <= 1'b0;
    @(posedge core_clk);
  endtask
  // Bounded wait for the reset output to reach a level
  task automatic wait_rst(input logic lvl, input int lim);
    k = 0;
    while (mcu_reset !== lvl && k < lim)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= lim)
    begin
      fails++;
      close_out();
    end
  endtask
  initial
  begin
    {rst_n, hw_option, reg_wr, reg_rd, stop_req, wake_irq} = '0;
    {reg_addr, reg_wdata} = '0;
    fails = 0;
    total_checks = 0;
    void'($urandom(34649));
    do_reset(1'b0);
    rd(8'hD8, 8'hFE);
    rd(8'h00, 8'h00);
    repeat (3)
    begin
      d = (8'($urandom) | 8'h02) & 8'hFE;
      wr(8'hD8, d);
      rd(8'hD8, d);
    end
    pulse(1'b0);
    `CHK("osc_halt", 1'b1, osc_halt)
    pulse(1'b1);
    `CHK("osc_halt", 1'b0, osc_halt)
    // Counter 65 steps to 64, then 63 drops the top bit while disarmed
    wr(8'hD8, 8'h82); // Soft-reset bit kept at one
    repeat (3100) @(posedge core_clk);
    rd(8'hD8, 8'h02);
    repeat (3072) @(posedge core_clk);
    rd(8'hD8, 8'hFC);
    `CHK("mcu_reset", 1'b0, mcu_reset)
    do_reset(1'b0);
    wr(8'hD8, 8'h83);
    wr(8'hD8, 8'h82); // Software reload while armed
    rd(8'hD8, 8'h83);
    wait_rst(1'b1, 7000);
    wait_rst(1'b0, 3000);
    `CHK("hold", 2048, k)
    rd(8'hD8, 8'hFE);
    wr(8'hD8, 8'hFF);
    repeat (1500) @(posedge core_clk);
    wr(8'hD8, 8'hFD);
    `CHK("mcu_reset", 1'b1, mcu_reset)
    wait_rst(1'b0, 3000);
    do_reset(1'b1);
    wr(8'hD8, 8'hFE);
    rd(8'hD8, 8'hFF);
    pulse(1'b0);
    `CHK("active", 1'b1, active)
    `CHK("osc_halt", 1'b0, osc_halt)
    close_out();
  end
endmodule
